// ---- common/tcs_defs.svh ----
// Offsets, field positions and reset values of the timer status block.
// Assumes AXI4-Lite byte addresses, one 32-bit word per register.
// What this block does
// - Channel 1 sets match-B flag, status bit 7, on counter equal constant B.
// - Channel 1 sets match-A flag, status bit 6, on counter equal constant A.
// - Channel 1 sets wrap flag, status bit 5, when counter wraps FF to 00.
// - A flag clears only on a write of 0 after reading it as 1.
// - Writing 1 to a flag bit leaves the flag unchanged.
// - Channel 1 status bit 4 always reads 1 and ignores writes.
// - Channel 1 match B drives its pin per bits 3:2: keep, low, high, toggle.
// - Channel 1 match A drives its pin per bits 1:0, same encoding.
// - Channel X sets match-B flag, status bit 7, on counter equal constant B.
// - Channel X sets match-A flag, status bit 6, on counter equal constant A.
// - Channel X sets wrap flag, status bit 5, when counter wraps FF to 00.
// - Channel X sets capture flag, bit 4, after rise then fall of reset input.
// - Capture flag clears only on a write of 0 after reading it as 1.
// - Channel X match B drives its pin per bits 3:2: keep, low, high, toggle.
// - Channel X match A drives its pin per bits 1:0, same encoding.
// - Capture request is high only when capture flag and its enable are 1.
// - With start bit set, counter is copied on rise, then on fall.
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

`define TCS_ADDR_W      8
`define TCS_T1_CS       8'h00
`define TCS_TX_CS       8'h04
`define TCS_T1_CNT      8'h08
`define TCS_T1_CA       8'h0C
`define TCS_T1_CB       8'h10
`define TCS_TX_CNT      8'h14
`define TCS_TX_CA       8'h18
`define TCS_TX_CB       8'h1C
`define TCS_CTRL        8'h20
`define TCS_CAP_RISE    8'h24
`define TCS_CAP_FALL    8'h28
`define TCS_IRQ_ST      8'h2C
`define TCS_IRQ_MASK    8'h30

`define TCS_RSV_BIT     4
`define TCS_RUN1_BIT    0
`define TCS_RUNX_BIT    1
`define TCS_CAPTURE_IRQ_ENABLE_BIT    2
`define TCS_START_BIT   3

`define TCS_CTRL_RST    4'h0
`define TCS_CNT_RST     8'h00
`define TCS_CONST_RST   8'hFF
`define TCS_CNT_MAX     8'hFF

`define TCS_RESP_OKAY   2'b00
`define TCS_RESP_DECERR 2'b11

`endif

// ---- common/tcs_pkg.sv ----
// Types shared by the timer status block.
// Assumes tcs_defs.svh for all numeric constants.
package tcs_pkg;

  // Four flags in the order of status bits 7 down to 4
  typedef struct packed {
    logic match_b;
    logic match_a;
    logic wrap;
    logic capture;
  } tcs_flags_s;

  typedef enum logic [1:0] {
    CAP_RISE = 2'b01,
    CAP_FALL = 2'b10
  } tcs_cap_e;

endpackage

// ---- core/tcs_top.sv ----
// Control and status logic of timer channels 1 and X with an AXI4-Lite
// register slave. Assumes one 100 MHz clock and synchronous inputs.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "tcs_defs.svh"

module tcs_top
  import tcs_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`TCS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`TCS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   timerx_ext_reset_in,
  output logic                        timer1_out_pin,
  output logic                        timerx_out_pin,
  output logic                        capture_irq_request,
  output logic                        irq
);

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [`TCS_ADDR_W-1:0] a,
                               input logic [`TCS_ADDR_W-1:0] off);
    hit = (a[`TCS_ADDR_W-1:2] == off[`TCS_ADDR_W-1:2]);
  endfunction

  function automatic logic mapped(input logic [`TCS_ADDR_W-1:0] a);
    mapped = (a[`TCS_ADDR_W-1:2] <= `TCS_IRQ_MASK >> 2);
  endfunction

  // Pin action: 00 keep, 01 low, 10 high, 11 toggle
  function automatic logic act(input logic [1:0] sel,
                               input logic       cur,
                               input logic       fire);
    act = cur;
    if (fire) begin
      case (sel)
        2'b01:   act = 1'b0;
        2'b10:   act = 1'b1;
        2'b11:   act = ~cur;
        default: act = cur;
      endcase
    end
  endfunction

  // ==========================================================
  // State
  logic [`TCS_ADDR_W-1:0] aw_addr_reg;
  logic [31:0]            w_data_reg;
  logic [3:0]             w_strb_reg;
  logic                   aw_got_reg;
  logic                   w_got_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [31:0]            rdata_reg;
  logic [1:0]             rresp_reg;
  logic [7:0]             t1_cnt_reg;
  logic [7:0]             t1_ca_reg;
  logic [7:0]             t1_cb_reg;
  logic [7:0]             tx_cnt_reg;
  logic [7:0]             tx_ca_reg;
  logic [7:0]             tx_cb_reg;
  tcs_flags_s             t1_flag_reg;
  tcs_flags_s             tx_flag_reg;
  tcs_flags_s             t1_arm_reg;
  tcs_flags_s             tx_arm_reg;
  logic [3:0]             t1_sel_reg;
  logic [3:0]             tx_sel_reg;
  logic [3:0]             ctrl_reg;
  logic [7:0]             capture_rise_reg;
  logic [7:0]             capture_fall_reg;
  logic [6:0]             irq_st_reg;
  logic [6:0]             irq_mask_reg;
  logic                   t1_pin_reg;
  logic                   tx_pin_reg;
  logic                   ext_prev_reg;
  tcs_cap_e               cap_state_reg;

  // ==========================================================
  // AXI4-Lite handshakes
  logic                   aw_have;
  logic                   w_have;
  logic                   wr_fire;
  logic                   ar_fire;
  logic                   wr_en;
  logic [`TCS_ADDR_W-1:0] wa;
  logic [31:0]            wd;
  logic [3:0]             ws;

  assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  assign aw_have = aw_got_reg | (s_axi_awvalid & s_axi_awready);
  assign w_have  = w_got_reg | (s_axi_wvalid & s_axi_wready);
  assign wr_fire = aw_have & w_have;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign wa      = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
  assign wd      = w_got_reg ? w_data_reg : s_axi_wdata;
  assign ws      = w_got_reg ? w_strb_reg : s_axi_wstrb;
  // Registers are one byte wide; only lane 0 carries them
  assign wr_en   = wr_fire & ws[0] & mapped(wa);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TCS_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= mapped(wa) ? `TCS_RESP_OKAY : `TCS_RESP_DECERR;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_got_reg  <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_got_reg  <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (bvalid_reg & s_axi_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Write strobes per register
  logic wr_t1_cs;
  logic wr_tx_cs;
  logic wr_t1_cnt;
  logic wr_tx_cnt;
  logic rd_t1_cs;
  logic rd_tx_cs;

  assign wr_t1_cs  = wr_en & hit(wa, `TCS_T1_CS);
  assign wr_tx_cs  = wr_en & hit(wa, `TCS_TX_CS);
  assign wr_t1_cnt = wr_en & hit(wa, `TCS_T1_CNT);
  assign wr_tx_cnt = wr_en & hit(wa, `TCS_TX_CNT);
  assign rd_t1_cs  = ar_fire & hit(s_axi_araddr, `TCS_T1_CS);
  assign rd_tx_cs  = ar_fire & hit(s_axi_araddr, `TCS_TX_CS);

  // ==========================================================
  // Counters and events
  logic       t1_tick;
  logic       tx_tick;
  logic [7:0] t1_inc;
  logic [7:0] tx_inc;
  tcs_flags_s t1_ev;
  tcs_flags_s tx_ev;
  logic       ext_rise;
  logic       ext_fall;

  // A software write to a counter wins over counting in that cycle
  assign t1_tick = ctrl_reg[`TCS_RUN1_BIT] & ~wr_t1_cnt;
  assign tx_tick = ctrl_reg[`TCS_RUNX_BIT] & ~wr_tx_cnt;
  assign t1_inc  = t1_cnt_reg + 8'h01;
  assign tx_inc  = tx_cnt_reg + 8'h01;
  assign ext_rise = timerx_ext_reset_in & ~ext_prev_reg;
  assign ext_fall = ~timerx_ext_reset_in & ext_prev_reg;

  // Events fire at the edge where the counter takes the matching value
  assign t1_ev.match_b = t1_tick & (t1_inc == t1_cb_reg);
  assign t1_ev.match_a = t1_tick & (t1_inc == t1_ca_reg);
  assign t1_ev.wrap    = t1_tick & (t1_cnt_reg == `TCS_CNT_MAX);
  assign t1_ev.capture = 1'b0;
  assign tx_ev.match_b = tx_tick & (tx_inc == tx_cb_reg);
  assign tx_ev.match_a = tx_tick & (tx_inc == tx_ca_reg);
  assign tx_ev.wrap    = tx_tick & (tx_cnt_reg == `TCS_CNT_MAX);
  assign tx_ev.capture = (cap_state_reg == CAP_FALL) & ext_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_cnt_reg <= `TCS_CNT_RST;
      tx_cnt_reg <= `TCS_CNT_RST;
    end else begin
      if (wr_t1_cnt) begin
        t1_cnt_reg <= wd[7:0];
      end else if (t1_tick) begin
        t1_cnt_reg <= t1_inc;
      end
      if (wr_tx_cnt) begin
        tx_cnt_reg <= wd[7:0];
      end else if (tx_tick) begin
        tx_cnt_reg <= tx_inc;
      end
    end
  end

  // ==========================================================
  // Plain read/write registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_ca_reg    <= `TCS_CONST_RST;
      t1_cb_reg    <= `TCS_CONST_RST;
      tx_ca_reg    <= `TCS_CONST_RST;
      tx_cb_reg    <= `TCS_CONST_RST;
      t1_sel_reg   <= 4'h0;
      tx_sel_reg   <= 4'h0;
      irq_mask_reg <= 7'h00;
    end else begin
      if (wr_en & hit(wa, `TCS_T1_CA)) t1_ca_reg <= wd[7:0];
      if (wr_en & hit(wa, `TCS_T1_CB)) t1_cb_reg <= wd[7:0];
      if (wr_en & hit(wa, `TCS_TX_CA)) tx_ca_reg <= wd[7:0];
      if (wr_en & hit(wa, `TCS_TX_CB)) tx_cb_reg <= wd[7:0];
      if (wr_t1_cs) t1_sel_reg <= wd[3:0];
      if (wr_tx_cs) tx_sel_reg <= wd[3:0];
      if (wr_en & hit(wa, `TCS_IRQ_MASK)) irq_mask_reg <= wd[6:0];
    end
  end

  // ==========================================================
  // Status flags: read as 1 arms the clear, a written 0 then clears
  tcs_flags_s t1_clr;
  tcs_flags_s tx_clr;

  // Written ones are masked out by ~wd, so they never clear
  assign t1_clr = {4{wr_t1_cs}} & ~wd[7:4] & t1_arm_reg;
  assign tx_clr = {4{wr_tx_cs}} & ~wd[7:4] & tx_arm_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_flag_reg <= '0;
      tx_flag_reg <= '0;
      t1_arm_reg  <= '0;
      tx_arm_reg  <= '0;
    end else begin
      // Event ORed last so a same-cycle clear cannot lose it
      t1_flag_reg <= t1_ev | (t1_flag_reg & ~t1_clr);
      tx_flag_reg <= tx_ev | (tx_flag_reg & ~tx_clr);
      if (rd_t1_cs) begin
        t1_arm_reg <= t1_arm_reg | t1_flag_reg;
      end else if (wr_t1_cs) begin
        t1_arm_reg <= '0;
      end
      if (rd_tx_cs) begin
        tx_arm_reg <= tx_arm_reg | tx_flag_reg;
      end else if (wr_tx_cs) begin
        tx_arm_reg <= '0;
      end
    end
  end

  // ==========================================================
  // Control: run bits, capture enable, capture start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `TCS_CTRL_RST;
    end else if (wr_en & hit(wa, `TCS_CTRL)) begin
      ctrl_reg <= wd[3:0];
    end else if (tx_ev.capture) begin
      // One capture operation ends at the falling edge
      ctrl_reg[`TCS_START_BIT] <= 1'b0;
    end
  end

  // ==========================================================
  // Capture sequence on the external reset input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_reg     <= 1'b0;
      cap_state_reg    <= CAP_RISE;
      capture_rise_reg <= 8'h00;
      capture_fall_reg <= 8'h00;
    end else begin
      ext_prev_reg <= timerx_ext_reset_in;
      case (cap_state_reg)
        CAP_RISE: begin
          if (ext_rise) begin
            cap_state_reg <= CAP_FALL;
            if (ctrl_reg[`TCS_START_BIT]) begin
              capture_rise_reg <= tx_cnt_reg;
            end
          end
        end
        CAP_FALL: begin
          if (ext_fall) begin
            cap_state_reg <= CAP_RISE;
            if (ctrl_reg[`TCS_START_BIT]) begin
              capture_fall_reg <= tx_cnt_reg;
            end
          end
        end
        default: cap_state_reg <= CAP_RISE;
      endcase
    end
  end

  // ==========================================================
  // Output pins; a match B applied after A wins a tie
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_pin_reg <= 1'b0;
      tx_pin_reg <= 1'b0;
    end else begin
      t1_pin_reg <= act(t1_sel_reg[3:2],
                        act(t1_sel_reg[1:0], t1_pin_reg,
                            t1_ev.match_a), t1_ev.match_b);
      tx_pin_reg <= act(tx_sel_reg[3:2],
                        act(tx_sel_reg[1:0], tx_pin_reg,
                            tx_ev.match_a), tx_ev.match_b);
    end
  end

  assign timer1_out_pin = t1_pin_reg;
  assign timerx_out_pin = tx_pin_reg;

  // ==========================================================
  // Interrupts: bits 2:0 channel 1 B/A/wrap, 6:3 channel X B/A/wrap/capture
  logic [6:0] irq_ev;

  assign irq_ev = {tx_ev, t1_ev.match_b, t1_ev.match_a, t1_ev.wrap};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_reg <= 7'h00;
    end else begin
      irq_st_reg <= irq_ev | (irq_st_reg &
                    ~((wr_en & hit(wa, `TCS_IRQ_ST)) ? wd[6:0] : 7'h00));
    end
  end

  assign irq = |(irq_st_reg & irq_mask_reg);
  assign capture_irq_request = tx_flag_reg.capture &
                               ctrl_reg[`TCS_CAPTURE_IRQ_ENABLE_BIT];

  // ==========================================================
  // Read path
  logic [7:0] rd_mux;

  always_comb begin
    case (s_axi_araddr[`TCS_ADDR_W-1:2])
      `TCS_T1_CS >> 2:    rd_mux = {t1_flag_reg[3:1], 1'b1, t1_sel_reg};
      `TCS_TX_CS >> 2:    rd_mux = {tx_flag_reg, tx_sel_reg};
      `TCS_T1_CNT >> 2:   rd_mux = t1_cnt_reg;
      `TCS_T1_CA >> 2:    rd_mux = t1_ca_reg;
      `TCS_T1_CB >> 2:    rd_mux = t1_cb_reg;
      `TCS_TX_CNT >> 2:   rd_mux = tx_cnt_reg;
      `TCS_TX_CA >> 2:    rd_mux = tx_ca_reg;
      `TCS_TX_CB >> 2:    rd_mux = tx_cb_reg;
      `TCS_CTRL >> 2:     rd_mux = {4'h0, ctrl_reg};
      `TCS_CAP_RISE >> 2: rd_mux = capture_rise_reg;
      `TCS_CAP_FALL >> 2: rd_mux = capture_fall_reg;
      `TCS_IRQ_ST >> 2:   rd_mux = {1'b0, irq_st_reg};
      `TCS_IRQ_MASK >> 2: rd_mux = {1'b0, irq_mask_reg};
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `TCS_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_mux};
      rresp_reg  <= mapped(s_axi_araddr) ? `TCS_RESP_OKAY : `TCS_RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  match_b1_a: assert property (t1_tick && t1_inc == t1_cb_reg |=>
    t1_flag_reg.match_b && t1_cnt_reg == t1_cb_reg)
    else $error("ch1 match B flag not set");
  match_a1_a: assert property (t1_tick && t1_inc == t1_ca_reg |=>
    t1_flag_reg.match_a)
    else $error("ch1 match A flag not set");
  wrap1_set_a: assert property (t1_tick && t1_cnt_reg == 8'hFF |=>
    t1_flag_reg.wrap && t1_cnt_reg == 8'h00)
    else $error("ch1 wrap flag not set");
  clear_armed_a: assert property ($fell(t1_flag_reg.wrap) |->
    $past(t1_arm_reg.wrap) && $past(wr_t1_cs))
    else $error("ch1 wrap flag cleared without read");
  one_keeps_a: assert property (wr_t1_cs && wd[7] && t1_flag_reg.match_b
    |=> t1_flag_reg.match_b)
    else $error("writing 1 cleared a flag");
  rsv_bit_a: assert property (rd_t1_cs |=> rdata_reg[4])
    else $error("ch1 reserved bit read 0");
  pin_low_b1_a: assert property (t1_ev.match_b && t1_sel_reg[3:2] == 2'b01
    |=> !timer1_out_pin)
    else $error("ch1 pin not driven low");
  pin_tog_a1_a: assert property (t1_ev.match_a && !t1_ev.match_b &&
    t1_sel_reg[1:0] == 2'b11 |=> timer1_out_pin != $past(timer1_out_pin))
    else $error("ch1 pin not toggled");
  match_bx_a: assert property (tx_tick && tx_inc == tx_cb_reg |=>
    tx_flag_reg.match_b)
    else $error("chX match B flag not set");
  match_ax_a: assert property (tx_tick && tx_inc == tx_ca_reg |=>
    tx_flag_reg.match_a)
    else $error("chX match A flag not set");
  wrapx_set_a: assert property (tx_tick && tx_cnt_reg == 8'hFF |=>
    tx_flag_reg.wrap)
    else $error("chX wrap flag not set");
  cap_seq_a: assert property (cap_state_reg == CAP_RISE && ext_rise ##1
    ext_fall |=> tx_flag_reg.capture)
    else $error("capture flag not set after rise and fall");
  cap_clear_a: assert property ($fell(tx_flag_reg.capture) |->
    $past(tx_arm_reg.capture))
    else $error("capture flag cleared without read");
  pin_high_bx_a: assert property (tx_ev.match_b && tx_sel_reg[3:2] == 2'b10
    |=> timerx_out_pin)
    else $error("chX pin not driven high");
  pin_tog_ax_a: assert property (tx_ev.match_a && !tx_ev.match_b &&
    tx_sel_reg[1:0] == 2'b11 |=> timerx_out_pin != $past(timerx_out_pin))
    else $error("chX pin not toggled");
  cap_irq_a: assert property (capture_irq_request |->
    tx_flag_reg.capture && ctrl_reg[`TCS_CAPTURE_IRQ_ENABLE_BIT])
    else $error("capture request without flag and enable");
  cap_copy_a: assert property (cap_state_reg == CAP_RISE && ext_rise &&
    ctrl_reg[`TCS_START_BIT] |=> capture_rise_reg == $past(tx_cnt_reg))
    else $error("rise capture value wrong");
  set_wins_a: assert property (t1_ev.wrap && t1_clr.wrap |=>
    t1_flag_reg.wrap)
    else $error("event lost under clear");
  reset_val_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> t1_flag_reg == '0 && tx_flag_reg == '0 &&
    t1_sel_reg == 4'h0 && tx_sel_reg == 4'h0)
    else $error("flags or selects not zero after reset");

  cov_wrap_c:   cover property (t1_ev.wrap ##1 rd_t1_cs);
  cov_clear_c:  cover property (rd_tx_cs ##[1:20] $fell(tx_flag_reg.capture));
  cov_cap_c:    cover property (ctrl_reg[`TCS_START_BIT] && tx_ev.capture);
  cov_toggle_c: cover property (t1_ev.match_a && t1_sel_reg[1:0] == 2'b11);

endmodule

// ---- test/tb_timer_ctrl_status_ch1_chx.sv ----
// Self-checking bench for tcs_top: registers over AXI4-Lite, pins, irqs.
// Assumes the map of tcs_defs.svh and a 100 MHz clock.
`timescale 1ns/1ns
`include "tcs_defs.svh"

module tb_timer_ctrl_status_ch1_chx
  import tcs_pkg::*;
;
  logic        aclk, aresetn, awv, wv, bry, arv, rry, ext;
  logic        awr, wrd, bv, arr, rv, p1, px, creq, irq;
  logic [7:0]  awa, ara, ca, cb;
  logic [31:0] wd, rdat;
  logic [1:0]  br, rr, rs;
  logic [3:0]  flg [2];
  logic [3:0]  sel [2];
  logic        pin [2];
  int          mismatches, num_checks;

  tcs_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .timerx_ext_reset_in(ext), .timer1_out_pin(p1),
    .timerx_out_pin(px), .capture_irq_request(creq), .irq(irq));

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // ==========================================================
  // Bus tasks and compare
  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Handshakes are judged at the rising edge with pre-edge values
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    logic tb;
    @(posedge aclk);
    awa <= a;
    wd  <= {24'h0, d};
    awv <= 1'h1;
    wv  <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge aclk);
      tb = bv;
      r  = br;
      if (awv & awr) awv <= 1'h0;
      if (wv & wrd) wv <= 1'h0;
    end while (!tb);
    bry <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic tb;
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge aclk);
      tb = rv;
      d  = rdat;
      r  = rr;
      if (arv & arr) arv <= 1'h0;
    end while (!tb);
    rry <= 1'h0;
  endtask

  task automatic chk(input int c);
    logic [31:0] d;
    rd(c ? `TCS_TX_CS : `TCS_T1_CS, d, rs);
    cmp("status", {24'h0, flg[c] | (c ? 4'h0 : 4'h1), sel[c]}, d);
  endtask

  // Any write disarms, so a bare zero write must not clear
  task automatic clr(input int c);
    logic [7:0] st;
    st = c ? `TCS_TX_CS : `TCS_T1_CS;
    wr(st, {4'hF, sel[c]}, rs);
    wr(st, {4'h0, sel[c]}, rs);
    chk(c);
    wr(st, {4'h0, sel[c]}, rs);
    flg[c] = 4'h0;
    chk(c);
  endtask

  // k: 0 match A, 1 match B, 2 wrap; run is kept short to hit one event
  task automatic mt(input int c, input int k, input logic [1:0] code);
    sel[c] = k == 1 ? {code, 2'h0} : {2'h0, code};
    wr(c ? `TCS_TX_CS : `TCS_T1_CS, {4'hF, sel[c]}, rs);
    wr(c ? `TCS_TX_CNT : `TCS_T1_CNT,
       k == 0 ? ca - 8'h1 : k == 1 ? cb - 8'h1 : 8'hFE, rs);
    wr(`TCS_CTRL, c ? 8'h2 : 8'h1, rs);
    wr(`TCS_CTRL, 8'h0, rs);
    flg[c][k == 1 ? 3 : k == 0 ? 2 : 1] = 1'h1;
    if (k < 2 && code == 2'h1) pin[c] = 1'h0;
    if (k < 2 && code == 2'h2) pin[c] = 1'h1;
    if (k < 2 && code == 2'h3) pin[c] = ~pin[c];
    chk(c);
    @(negedge aclk);
    cmp("pin", {31'h0, pin[c]}, {31'h0, c ? px : p1});
    clr(c);
  endtask

  task automatic pulse(input int n);
    @(posedge aclk);
    ext <= 1'h1;
    repeat (n) @(posedge aclk);
    ext <= 1'h0;
    repeat (4) @(posedge aclk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d, r1;
    int          n;
    {aresetn, awv, wv, bry, arv, rry, ext} = 7'h0;
    {awa, ara, wd} = 48'h0;
    {mismatches, num_checks} = 0;
    flg = '{default: 4'h0};
    sel = '{default: 4'h0};
    pin = '{default: 1'h0};
    void'($urandom(32'hCF6D));
    ca = 8'h10 + 8'($urandom % 64);
    cb = ca + 8'h60;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    chk(0);
    chk(1);
    rd(8'h40, d, rs);
    cmp("rresp", {30'h0, rs}, 32'h3);
    wr(8'h40, 8'h0, rs);
    cmp("bresp", {30'h0, rs}, 32'h3);
    wr(`TCS_T1_CS, 8'hFF, rs);
    sel[0] = 4'hF;
    chk(0);
    wr(`TCS_T1_CA, ca, rs);
    wr(`TCS_T1_CB, cb, rs);
    wr(`TCS_TX_CA, ca, rs);
    wr(`TCS_TX_CB, cb, rs);
    wr(`TCS_IRQ_MASK, 8'h02, rs);
    cmp("irq", 32'h0, {31'h0, irq});
    for (int c = 0; c < 2; c++) begin
      for (int code = 0; code < 4; code++) begin
        mt(c, 0, 2'(code));
        mt(c, 1, 2'(code));
      end
      mt(c, 2, 2'h0);
    end
    cmp("irq", 32'h1, {31'h0, irq});
    wr(`TCS_IRQ_ST, 8'h00, rs);
    @(negedge aclk);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(`TCS_IRQ_ST, 8'h7F, rs);
    @(negedge aclk);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(`TCS_CTRL, 8'h04, rs);
    cmp("capreq", 32'h0, {31'h0, creq});
    pulse(3);
    flg[1][0] = 1'h1;
    chk(1);
    cmp("capreq", 32'h1, {31'h0, creq});
    clr(1);
    @(negedge aclk);
    cmp("capreq", 32'h0, {31'h0, creq});
    n = 3 + $urandom % 6;
    wr(`TCS_CTRL, 8'h0A, rs);
    pulse(n);
    rd(`TCS_CTRL, d, rs);
    cmp("ctrl", 32'h2, d);
    rd(`TCS_CAP_RISE, r1, rs);
    rd(`TCS_CAP_FALL, d, rs);
    cmp("span", 32'(n), {24'h0, d[7:0] - r1[7:0]});
    close_out();
  end

  // Tests need about 700 cycles; over forty times that is a hang
  initial begin
    #300000;
    mismatches++;
    close_out();
  end
endmodule
